// ==== dv/osdfc_frame_control_monitor.sv ====
// Purpose: Port-level assertions for the frame control registers.
// Assumes: Derived outputs settle two enabled edges after a write.
// Notes: A clock-enable gap voids the write checks, so they require it.
`timescale 1ns/1ps
module osdfc_frame_control_monitor
  import osdfc_pkg::*;
#(
  parameter int TRANS_CYCLES = TRANS_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic regWrEn,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [9:0] vertStartLines,
  input wire logic [10:0] horizStartDots,
  input wire logic [6:0] charLines,
  input wire logic [10:0] pixelsPerLine,
  input wire logic [4:0] rowGapLines,
  input wire logic windowClearPulse,
  input wire logic screenClearPulse,
  input wire logic [4:0] fontLines,
  input wire logic glyphLineSkip,
  input wire logic [1:0] oscRangeField,
  input wire logic [1:0] pwmClkDivLog2,
  input wire logic fastBlankingOut,
  input wire logic fastBlankingOe
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic wrOk;
  assign wrOk = clk_en & regWrEn;
  vert_scale_a: assert property (wrOk && regAddr == COL_VERT_START ##1 clk_en |=>
    vertStartLines == {$past(regWrData, 2), 2'h0}) else $error("vertical start wrong");
  horiz_scale_a: assert property (wrOk && regAddr == COL_HORIZ_START ##1 clk_en |=>
    horizStartDots == 11'($past(regWrData, 2)) * HORIZ_STEP_DOTS) else $error("horiz wrong");
  char_range_a: assert property (charLines >= CHAR_H_MIN && charLines <= CHAR_H_MAX)
    else $error("character height out of range");
  line_pixels_a: assert property (wrOk && regAddr == COL_LINE_RES ##1 clk_en |=>
    pixelsPerLine == 11'($past(regWrData, 2) & 8'h7F) * PIXEL_STEP) else $error("pixels wrong");
  row_gap_a: assert property (wrOk && regAddr == COL_ROW_GAP ##1 clk_en |=>
    rowGapLines == $past(regWrData[4:0], 2)) else $error("row gap wrong");
  win_clear_a: assert property (wrOk && regAddr == COL_DISP_CTRL && regWrData[DC_WIN_CLEAR]
    |-> ##[1:2] windowClearPulse) else $error("window clear pulse missing");
  screen_pulse_a: assert property (screenClearPulse && $past(clk_en) |->
    $past(wrOk && regAddr == COL_DISP_CTRL && regWrData[DC_SCREEN_CLEAR]))
    else $error("screen clear pulse without write");
  font_lines_a: assert property (fontLines == (glyphLineSkip ? FONT_SHORT_LINES :
    FONT_TALL_LINES)) else $error("font lines disagree with skip");
  osc_range_a: assert property (wrOk && regAddr == COL_SYNC_CTRL ##1 clk_en |=>
    oscRangeField == $past(regWrData[1:0], 2)) else $error("range field wrong");
  pwm_div_a: assert property (pwmClkDivLog2 == oscRangeField)
    else $error("pwm divider differs from range");
  test_blank_a: assert property (wrOk && regAddr == COL_TEST_PAT && regWrData[TP_ENABLE]
    ##1 clk_en |=> fastBlankingOut && fastBlankingOe) else $error("self-test not blanking");
endmodule : osdfc_frame_control_monitor
bind osdfc_frame_control osdfc_frame_control_monitor #(.TRANS_CYCLES(TRANS_CYCLES)) mon_i (
  .core_clk, .rst_b, .clk_en, .regWrEn, .regAddr, .regWrData, .vertStartLines,
  .horizStartDots, .charLines, .pixelsPerLine, .rowGapLines, .windowClearPulse,
  .screenClearPulse, .fontLines, .glyphLineSkip, .oscRangeField, .pwmClkDivLog2,
  .fastBlankingOut, .fastBlankingOe
);

// ==== dv/osdfc_host_model.sv ====
// Purpose: Microcontroller side of the frame control register port.
// Assumes: The serial slave hands over one byte per strobe.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
module osdfc_host_model
  import osdfc_pkg::*;
#(
  parameter int SETTLE = 8
) (
  input wire logic core_clk,
  input wire logic [7:0] regRdData,
  output logic regWrEn,
  output logic regRdEn,
  output logic [4:0] regAddr,
  output logic [7:0] regWrData
);
  // ==========================================================================
  // Bus cycles
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 5'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #2;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    if (a == COL_LINE_RES || a == COL_SYNC_CTRL) repeat (SETTLE) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #2;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #2;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : osdfc_host_model

// ==== dv/test_osdfc_frame_control.sv ====
// Purpose: Self-checking bench for the frame control registers.
// Assumes: A short transition parameter keeps fades to a few thousand cycles.
// Notes: The model keeps written bytes; reads mask reserved and clear bits.
`timescale 1ns/1ps
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module test_osdfc_frame_control;
  import osdfc_pkg::*;
  // ==========================================================================
  // Bench
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic horizFlybackIn = 1'b0;
  logic vertFlybackIn = 1'b0;
  logic charActive = 1'b0;
  logic winActive = 1'b0;
  logic [2:0] pixelRgb = 3'h5;
  logic regWrEn, regRdEn, displayActive, edgeEffectEnable, edgeShadowSel, blendSel;
  logic windowClearPulse, screenClearPulse, glyphLineSkip, measureActive, measureDone;
  logic horizEdgeEvent, vertEdgeEvent, redVideoOut, redVideoOe, greenVideoOut;
  logic greenVideoOe, blueVideoOut, blueVideoOe, fastBlankingOut, fastBlankingOe;
  logic [4:0] regAddr, rowGapLines, fontLines;
  logic [7:0] regWrData, regRdData, fadeLevel;
  logic [9:0] vertStartLines;
  logic [10:0] horizStartDots, pixelsPerLine;
  logic [6:0] charLines;
  logic [2:0] edgeColorField;
  logic [1:0] oscRangeField, pwmClkDivLog2;
  logic [15:0] shadowWidths, shadowHeights;
  int fails = 0;
  int comparisons = 0;
  int seed = 32'h52a6;
  int m[12:22] = '{4, 15, 0, 40, 0, 0, 0, 0, 0, 0, 0};
  int msk[12:22] = '{255, 255, 127, 127, 31, 249, 255, 7, 135, 255, 255};
  osdfc_frame_control #(.TRANS_CYCLES(2550)) osdfc_frame_control_i (
    .core_clk, .rst_b, .clk_en, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .horizFlybackIn, .vertFlybackIn, .charActive, .winActive, .pixelRgb, .vertStartLines,
    .horizStartDots, .charLines, .pixelsPerLine, .rowGapLines, .displayActive,
    .edgeEffectEnable, .edgeShadowSel, .edgeColorField, .fadeLevel, .blendSel,
    .windowClearPulse, .screenClearPulse, .fontLines, .glyphLineSkip, .measureActive,
    .measureDone, .horizEdgeEvent, .vertEdgeEvent, .oscRangeField, .pwmClkDivLog2,
    .shadowWidths, .shadowHeights, .redVideoOut, .redVideoOe, .greenVideoOut,
    .greenVideoOe, .blueVideoOut, .blueVideoOe, .fastBlankingOut, .fastBlankingOe
  );
  osdfc_host_model host_i (.core_clk, .regRdData, .regWrEn, .regRdEn, .regAddr, .regWrData);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [15:0] shd(input int v);
    for (int i = 0; i < 4; i++) shd[4 * i +: 4] = 4'(((v >> (2 * i)) & 3) * 2 + 2);
  endfunction : shd
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #2;
  endtask : settle
  task automatic chk_all();
    int h;
    logic [7:0] d;
    h = m[14] & 127;
    h = h < 18 ? h + 18 : (h > 71 ? 71 : h);
    `CHK(vertStartLines, 10'(m[12] * 4))
    `CHK(horizStartDots, 11'(m[13] * 6))
    `CHK(charLines, 7'(h))
    `CHK(pixelsPerLine, 11'((m[15] & 127) * 12))
    `CHK(rowGapLines, 5'(m[16]))
    `CHK({edgeEffectEnable, edgeShadowSel, edgeColorField}, {2'(m[17] >> 5), 3'(m[19])})
    `CHK(blendSel, 1'(m[17] >> 3))
    `CHK(fontLines, m[18][6] ? 5'h12 : 5'h10)
    `CHK(pwmClkDivLog2, 2'(m[18]))
    `CHK({shadowWidths, shadowHeights}, {shd(m[21]), shd(m[22])})
    for (int c = 12; c <= 22; c++) begin
      host_i.rd(5'(c), d);
      `CHK(d, 8'(m[c] & msk[c]))
    end
  endtask : chk_all
  task automatic put(input int c, input int d);
    host_i.wr(5'(c), 8'(d));
    m[c] = d & 255;
    settle();
    chk_all();
  endtask : put
  task automatic wait_lvl(input logic [7:0] v);
    int n;
    for (n = 0; n < 4000 && fadeLevel !== v; n++) @(posedge core_clk);
    if (n == 4000) begin
      fails++;
      report_and_stop();
    end
    settle();
  endtask : wait_lvl
  task automatic pulse(input bit vert, input bit look, output int at);
    at = -1;
    for (int i = 0; i < 20; i++) begin
      horizFlybackIn = !vert && i < 8;
      vertFlybackIn = vert && i < 8;
      @(posedge core_clk);
      #2;
      if (at < 0 && (look ? vertEdgeEvent : horizEdgeEvent) === 1'b1) at = i;
    end
  endtask : pulse
  initial begin
    #1ms;
    fails++;
    report_and_stop();
  end
  initial begin
    int k;
    logic [7:0] d;
    repeat (16) @(posedge core_clk);
    #2 rst_b = 1'b1;
    host_i.wr(5'h1F, 8'hFF);
    settle();
    chk_all();
    host_i.rd(5'h1F, d);
    `CHK(d, 8'h00)
    `CHK({displayActive, redVideoOe, fastBlankingOe}, 3'h0)
    clk_en = 1'b0;
    host_i.wr(COL_ROW_GAP, 8'h15);
    clk_en = 1'b1;
    settle();
    `CHK(rowGapLines, 5'h00)
    foreach (msk[c]) put(c, 8'($random(seed)));
    repeat (30) put(12 + int'($unsigned($random(seed)) % 11), 8'($random(seed)));
    foreach (msk[c]) put(c, 255);
    foreach (msk[c]) put(c, 0);
    for (int v = 0; v < 8; v++) put(COL_CHAR_HEIGHT, v * 18 + (v & 1) - 1);
    host_i.wr(COL_DISP_CTRL, 8'h06);
    k = 0;
    repeat (3) begin
      k += {windowClearPulse, screenClearPulse} === 2'b11;
      @(posedge core_clk);
      #2;
    end
    `CHK(k, 1)
    put(17, 8'h80);
    winActive = 1'b1;
    pixelRgb = 3'($random(seed));
    settle();
    `CHK({displayActive, fastBlankingOut, redVideoOe}, 3'h7)
    `CHK({redVideoOut, greenVideoOut, blueVideoOut}, pixelRgb)
    put(17, 8'h81);
    `CHK(fastBlankingOut, 1'b0)
    charActive = 1'b1;
    settle();
    `CHK(fastBlankingOut, 1'b1)
    put(17, 8'h00);
    `CHK({displayActive, redVideoOe, blueVideoOe, fastBlankingOe}, 4'h0)
    put(18, 8'h80);
    `CHK({redVideoOe, greenVideoOe, fastBlankingOe, redVideoOut, fastBlankingOut}, 5'h1C)
    put(20, 8'h85);
    `CHK({fastBlankingOut, redVideoOut, greenVideoOut, blueVideoOut}, 4'hD)
    put(20, 0);
    put(17, 8'h90);
    repeat (1200) @(posedge core_clk);
    #2;
    `CHK(fadeLevel > 8'h20 && fadeLevel < 8'hE0, 1'b1)
    wait_lvl(FADE_FULL);
    put(17, 8'h18);
    `CHK(displayActive, 1'b1)
    wait_lvl(8'h00);
    `CHK(displayActive, 1'b0)
    put(18, 8'h2C);
    pulse(0, 0, k);
    `CHK(k >= 2 && k <= 5, 1'b1)
    pulse(1, 1, k);
    `CHK({measureActive, measureDone}, 2'b10)
    pulse(1, 1, k);
    `CHK(measureDone, 1'b1)
    put(18, 8'h20);
    pulse(0, 0, k);
    `CHK(k >= 10 && k <= 13, 1'b1)
    put(18, 8'h1C);
    pulse(1, 1, k);
    `CHK(k, -1)
    pulse(0, 1, k);
    `CHK(k >= 2 && k <= 5, 1'b1)
    report_and_stop();
  end
endmodule : test_osdfc_frame_control

// ==== hdl/osdfc_frame_control.sv ====
// Purpose: Frame control registers of the on-screen display and the logic they steer.
// Assumes: The serial slave decodes row 15 and presents column, data and strobes.
// Notes: Sync pins are synchronised here; pixel pipeline inputs share core_clk.
//
// What this block does
// - Vertical start equals register times four lines; resets to 4.
// - Horizontal start equals register times six dots; resets to 15.
// - Character height 18 to 71 lines; values below 18 get 18 added.
// - Pixels per line equal resolution times twelve; resets to 40.
// - Row gap appends 0 to 31 extra lines per row; resets to 0.
// - Display runs while the enable bit is set or a fade-out is running; resets cleared.
// - Edge effect draws shadow or four-sided border in a 3-bit colour.
// - Display switching fades or blends over about half a second.
// - Writing window-clear as 1 clears every window enable bit.
// - Writing screen-clear as 1 clears addresses, backgrounds and blink bits.
// - Blanking output follows characters or windows, or characters only.
// - While disabled and not in self-test, colour and blanking pins drive low or float.
// - Font size bit picks 18-line glyphs or 16 lines skipping first and last.
// - Measurement starts at next vertical flyback, ends one frame later.
// - Collision detect aligns vertical sync edges to horizontal sync.
// - Polarity bits select positive or negative sync inputs.
// - Two-bit oscillator range field selects pixel rate band; resets 00.
// - PWM clock is pixel rate over 1, 2, 4 or 8; sampling over 256.
// - Self-test shows a full-screen colour and forces blanking high.
// - Window shadow width codes give 2, 4, 6 or 8 pixels.
// - Window shadow height codes give 2, 4, 6 or 8 lines.

`timescale 1ns/1ps

module osdfc_frame_control
  import osdfc_pkg::*;
#(
  parameter int TRANS_CYCLES = TRANS_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic horizFlybackIn,
  input wire logic vertFlybackIn,
  input wire logic charActive,
  input wire logic winActive,
  input wire logic [2:0] pixelRgb,
  output logic [9:0] vertStartLines,
  output logic [10:0] horizStartDots,
  output logic [6:0] charLines,
  output logic [10:0] pixelsPerLine,
  output logic [4:0] rowGapLines,
  output logic displayActive,
  output logic edgeEffectEnable,
  output logic edgeShadowSel,
  output logic [2:0] edgeColorField,
  output logic [7:0] fadeLevel,
  output logic blendSel,
  output logic windowClearPulse,
  output logic screenClearPulse,
  output logic [4:0] fontLines,
  output logic glyphLineSkip,
  output logic measureActive,
  output logic measureDone,
  output logic horizEdgeEvent,
  output logic vertEdgeEvent,
  output logic [1:0] oscRangeField,
  output logic [1:0] pwmClkDivLog2,
  output logic [15:0] shadowWidths,
  output logic [15:0] shadowHeights,
  output logic redVideoOut,
  output logic redVideoOe,
  output logic greenVideoOut,
  output logic greenVideoOe,
  output logic blueVideoOut,
  output logic blueVideoOe,
  output logic fastBlankingOut,
  output logic fastBlankingOe
);

  // ==========================================================================
  // Register storage
  localparam int FADE_STEP = (TRANS_CYCLES / 255 > 0) ? TRANS_CYCLES / 255 : 1;
  localparam logic [24:0] FADE_STEP_LAST = 25'(FADE_STEP - 1);

  logic [7:0] vertStartReg, horizStartReg, dispCtrlReg, syncCtrlReg, shadowWReg, shadowHReg;
  logic [6:0] charHeightReg, lineResReg;
  logic [4:0] rowGapReg;
  logic [2:0] edgeColorReg;
  logic [3:0] testPatReg;

  wire regWrite = clk_en & regWrEn;
  wire wrDispCtrl = regWrite & (regAddr == COL_DISP_CTRL);
  wire wrSyncCtrl = regWrite & (regAddr == COL_SYNC_CTRL);

  // Clear bits are command bits: they act on the write and never stay set,
  // so a later write of other control bits cannot repeat the clear.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vertStartReg <= RST_VERT_START;
      horizStartReg <= RST_HORIZ_START;
      charHeightReg <= RST_CHAR_HEIGHT;
      lineResReg <= RST_LINE_RES;
      rowGapReg <= RST_ROW_GAP;
      dispCtrlReg <= RST_DISP_CTRL;
      syncCtrlReg <= RST_SYNC_CTRL;
      edgeColorReg <= RST_EDGE_COLOR;
      testPatReg <= RST_TEST_PAT;
      shadowWReg <= RST_SHADOW;
      shadowHReg <= RST_SHADOW;
    end else if (regWrite) begin
      case (regAddr)
        COL_VERT_START: vertStartReg <= regWrData;
        COL_HORIZ_START: horizStartReg <= regWrData;
        COL_CHAR_HEIGHT: charHeightReg <= regWrData[6:0];
        COL_LINE_RES: lineResReg <= regWrData[6:0];
        COL_ROW_GAP: rowGapReg <= regWrData[4:0];
        COL_DISP_CTRL: dispCtrlReg <= regWrData & ~DC_PULSE_MASK;
        COL_SYNC_CTRL: syncCtrlReg <= regWrData;
        COL_EDGE_COLOR: edgeColorReg <= regWrData[2:0];
        COL_TEST_PAT: testPatReg <= {regWrData[TP_ENABLE], regWrData[2:0]};
        COL_SHADOW_W: shadowWReg <= regWrData;
        COL_SHADOW_H: shadowHReg <= regWrData;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Read back
  logic [7:0] rdMux;

  always_comb begin
    case (regAddr)
      COL_VERT_START: rdMux = vertStartReg;
      COL_HORIZ_START: rdMux = horizStartReg;
      COL_CHAR_HEIGHT: rdMux = {1'b0, charHeightReg};
      COL_LINE_RES: rdMux = {1'b0, lineResReg};
      COL_ROW_GAP: rdMux = {3'h0, rowGapReg};
      COL_DISP_CTRL: rdMux = dispCtrlReg;
      COL_SYNC_CTRL: rdMux = syncCtrlReg;
      COL_EDGE_COLOR: rdMux = {5'h00, edgeColorReg};
      COL_TEST_PAT: rdMux = {testPatReg[3], 4'h0, testPatReg[2:0]};
      COL_SHADOW_W: rdMux = shadowWReg;
      COL_SHADOW_H: rdMux = shadowHReg;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (clk_en && regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // ==========================================================================
  // Frame geometry
  // Height clamp rules
  wire [6:0] charLinesNext = (charHeightReg < CHAR_H_MIN) ? charHeightReg + CHAR_H_MIN :
                             (charHeightReg > CHAR_H_MAX) ? CHAR_H_MAX : charHeightReg;
  wire fontTall = syncCtrlReg[SC_FONT_SIZE];
  wire [4:0] fontLinesNext = fontTall ? FONT_TALL_LINES : FONT_SHORT_LINES;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vertStartLines <= 10'h000;
      horizStartDots <= 11'h000;
      charLines <= CHAR_H_MIN;
      pixelsPerLine <= 11'h000;
      rowGapLines <= RST_ROW_GAP;
      fontLines <= FONT_SHORT_LINES;
      glyphLineSkip <= 1'b1;
    end else if (clk_en) begin
      vertStartLines <= {2'b00, vertStartReg} * VERT_STEP_LINES;
      horizStartDots <= {3'b000, horizStartReg} * HORIZ_STEP_DOTS;
      charLines <= charLinesNext;
      pixelsPerLine <= {4'h0, lineResReg} * PIXEL_STEP;
      rowGapLines <= rowGapReg;
      fontLines <= fontLinesNext;
      glyphLineSkip <= ~fontTall;
    end
  end

  // ==========================================================================
  // Window shadow size: code n gives 2*(n+1).
  logic [15:0] shadowWNext, shadowHNext;

  for (genvar w = 0; w < 4; w++) begin : g_shadow
    assign shadowWNext[4*w +: 4] = {3'({1'b0, shadowWReg[2*w +: 2]}) + 3'h1, 1'b0};
    assign shadowHNext[4*w +: 4] = {3'({1'b0, shadowHReg[2*w +: 2]}) + 3'h1, 1'b0};
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shadowWidths <= 16'h2222;
      shadowHeights <= 16'h2222;
    end else if (clk_en) begin
      shadowWidths <= shadowWNext;
      shadowHeights <= shadowHNext;
    end
  end

  // ==========================================================================
  // Effects, clears and clock range
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      edgeEffectEnable <= 1'b0;
      edgeShadowSel <= 1'b0;
      edgeColorField <= RST_EDGE_COLOR;
      blendSel <= 1'b0;
      windowClearPulse <= 1'b0;
      screenClearPulse <= 1'b0;
      oscRangeField <= 2'b00;
      pwmClkDivLog2 <= 2'b00;
    end else if (clk_en) begin
      edgeEffectEnable <= dispCtrlReg[DC_EDGE_EN];
      edgeShadowSel <= dispCtrlReg[DC_EDGE_SHADOW];
      edgeColorField <= edgeColorReg;
      blendSel <= dispCtrlReg[DC_TRANS_BLEND];
      windowClearPulse <= wrDispCtrl & regWrData[DC_WIN_CLEAR];
      screenClearPulse <= wrDispCtrl & regWrData[DC_SCREEN_CLEAR];
      oscRangeField <= syncCtrlReg[1:0];
      pwmClkDivLog2 <= syncCtrlReg[1:0];
    end
  end

  // ==========================================================================
  // Fade and blend transition
  // The level ramps one step per FADE_STEP cycles, so a full swing takes the
  // whole transition time; the pipeline scales colour or mix by it.
  logic [24:0] fadeCntReg;
  wire displayEnableBit = dispCtrlReg[DC_DISPLAY_EN];
  wire transitionEnable = dispCtrlReg[DC_TRANS_EN];
  wire [7:0] fadeTarget = displayEnableBit ? FADE_FULL : 8'h00;
  wire fadeTick = (fadeCntReg == FADE_STEP_LAST);
  wire fadeMoving = (fadeLevel != fadeTarget);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fadeLevel <= 8'h00;
      fadeCntReg <= 25'h0000000;
    end else if (clk_en) begin
      if (!transitionEnable || !fadeMoving) begin
        fadeLevel <= fadeTarget;
        fadeCntReg <= 25'h0000000;
      end else if (fadeTick) begin
        fadeLevel <= displayEnableBit ? fadeLevel + 8'h01 : fadeLevel - 8'h01;
        fadeCntReg <= 25'h0000000;
      end else begin
        fadeCntReg <= fadeCntReg + 25'h0000001;
      end
    end
  end

  // ==========================================================================
  // Sync inputs
  logic hSync1Reg, hSync2Reg, vSync1Reg, vSync2Reg;
  logic hActPrevReg, vActPrevReg, vPendingReg;

  wire hAct = syncCtrlReg[SC_HSYNC_POL] ? hSync2Reg : ~hSync2Reg;
  wire vAct = syncCtrlReg[SC_VSYNC_POL] ? vSync2Reg : ~vSync2Reg;
  wire hEdge = hAct & ~hActPrevReg;
  wire vEdge = vAct & ~vActPrevReg;
  wire collisionOn = syncCtrlReg[SC_COLLISION];
  wire vertEvent = collisionOn ? ((vPendingReg | vEdge) & hEdge) : vEdge;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hSync1Reg <= 1'b0;
      hSync2Reg <= 1'b0;
      vSync1Reg <= 1'b0;
      vSync2Reg <= 1'b0;
      // Starting high means a pin that idles at its active level gives no false edge.
      hActPrevReg <= 1'b1;
      vActPrevReg <= 1'b1;
    end else if (clk_en) begin
      hSync1Reg <= horizFlybackIn;
      hSync2Reg <= hSync1Reg;
      vSync1Reg <= vertFlybackIn;
      vSync2Reg <= vSync1Reg;
      hActPrevReg <= hAct;
      vActPrevReg <= vAct;
    end
  end

  // A vertical edge that lands between horizontal edges is held until the
  // next one, so it cannot be counted against the wrong line.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vPendingReg <= 1'b0;
      horizEdgeEvent <= 1'b0;
      vertEdgeEvent <= 1'b0;
    end else if (clk_en) begin
      if (!collisionOn || hEdge) begin
        vPendingReg <= 1'b0;
      end else if (vEdge) begin
        vPendingReg <= 1'b1;
      end
      horizEdgeEvent <= hEdge;
      vertEdgeEvent <= vertEvent;
    end
  end

  // ==========================================================================
  // Measurement sequencing
  osdfc_meas_t measState, measNext;
  wire measureBit = syncCtrlReg[SC_MEASURE];
  wire measureStart = wrSyncCtrl & regWrData[SC_MEASURE] & ~measureBit;

  always_comb begin
    measNext = measState;
    if (measureStart) begin
      measNext = MEAS_ARMED;
    end else if (!measureBit) begin
      measNext = MEAS_IDLE;
    end else begin
      unique case (measState)
        MEAS_IDLE: measNext = MEAS_IDLE;
        MEAS_ARMED: measNext = vertEvent ? MEAS_RUN : MEAS_ARMED;
        MEAS_RUN: measNext = vertEvent ? MEAS_DONE : MEAS_RUN;
        MEAS_DONE: measNext = MEAS_DONE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      measState <= MEAS_IDLE;
      measureActive <= 1'b0;
      measureDone <= 1'b0;
    end else if (clk_en) begin
      measState <= measNext;
      measureActive <= (measNext == MEAS_RUN);
      measureDone <= (measNext == MEAS_DONE);
    end
  end

  // ==========================================================================
  // Colour and blanking pins
  // The display stays active while a fade-out is still running.
  wire showing = displayEnableBit | (fadeLevel != 8'h00);
  wire selfTest = testPatReg[3];
  wire idleDrive = syncCtrlReg[SC_IDLE_DRIVE];
  wire blankSrc = dispCtrlReg[DC_BLANK_CFG] ? charActive : (charActive | winActive);
  wire [2:0] colourNext = selfTest ? testPatReg[2:0] : (showing ? pixelRgb : 3'h0);
  wire blankNext = selfTest | (showing & blankSrc);
  wire pinOeNext = selfTest | showing | idleDrive;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      displayActive <= 1'b0;
      redVideoOut <= 1'b0;
      greenVideoOut <= 1'b0;
      blueVideoOut <= 1'b0;
      fastBlankingOut <= 1'b0;
      redVideoOe <= 1'b0;
      greenVideoOe <= 1'b0;
      blueVideoOe <= 1'b0;
      fastBlankingOe <= 1'b0;
    end else if (clk_en) begin
      displayActive <= showing;
      redVideoOut <= colourNext[2];
      greenVideoOut <= colourNext[1];
      blueVideoOut <= colourNext[0];
      fastBlankingOut <= blankNext;
      redVideoOe <= pinOeNext;
      greenVideoOe <= pinOeNext;
      blueVideoOe <= pinOeNext;
      fastBlankingOe <= pinOeNext;
    end
  end

endmodule : osdfc_frame_control

// ==== hdl/osdfc_pkg.sv ====
// Purpose: Constants and types shared by the frame control register block.
// Assumes: Registers sit in row 15 and are selected by their column number.
// Notes: Column numbers are the register addresses used on the write port.

package osdfc_pkg;

  // ==========================================================================
  // Register columns
  localparam logic [4:0] COL_VERT_START = 5'h0C;
  localparam logic [4:0] COL_HORIZ_START = 5'h0D;
  localparam logic [4:0] COL_CHAR_HEIGHT = 5'h0E;
  localparam logic [4:0] COL_LINE_RES = 5'h0F;
  localparam logic [4:0] COL_ROW_GAP = 5'h10;
  localparam logic [4:0] COL_DISP_CTRL = 5'h11;
  localparam logic [4:0] COL_SYNC_CTRL = 5'h12;
  localparam logic [4:0] COL_EDGE_COLOR = 5'h13;
  localparam logic [4:0] COL_TEST_PAT = 5'h14;
  localparam logic [4:0] COL_SHADOW_W = 5'h15;
  localparam logic [4:0] COL_SHADOW_H = 5'h16;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] RST_VERT_START = 8'h04;
  localparam logic [7:0] RST_HORIZ_START = 8'h0F;
  localparam logic [6:0] RST_CHAR_HEIGHT = 7'h00;
  localparam logic [6:0] RST_LINE_RES = 7'h28;
  localparam logic [4:0] RST_ROW_GAP = 5'h00;
  localparam logic [7:0] RST_DISP_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [2:0] RST_EDGE_COLOR = 3'h0;
  localparam logic [3:0] RST_TEST_PAT = 4'h0;
  localparam logic [7:0] RST_SHADOW = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int DC_DISPLAY_EN = 7;
  localparam int DC_EDGE_EN = 6;
  localparam int DC_EDGE_SHADOW = 5;
  localparam int DC_TRANS_EN = 4;
  localparam int DC_TRANS_BLEND = 3;
  localparam int DC_WIN_CLEAR = 2;
  localparam int DC_SCREEN_CLEAR = 1;
  localparam int DC_BLANK_CFG = 0;
  localparam logic [7:0] DC_PULSE_MASK = 8'h06;
  localparam int SC_IDLE_DRIVE = 7;
  localparam int SC_FONT_SIZE = 6;
  localparam int SC_MEASURE = 5;
  localparam int SC_COLLISION = 4;
  localparam int SC_HSYNC_POL = 3;
  localparam int SC_VSYNC_POL = 2;
  localparam int TP_ENABLE = 7;

  // ==========================================================================
  // Scales and limits
  localparam logic [9:0] VERT_STEP_LINES = 10'h004;
  localparam logic [10:0] HORIZ_STEP_DOTS = 11'h006;
  localparam logic [10:0] PIXEL_STEP = 11'h00C;
  localparam logic [6:0] CHAR_H_MIN = 7'h12;
  localparam logic [6:0] CHAR_H_MAX = 7'h47;
  localparam logic [4:0] FONT_TALL_LINES = 5'h12;
  localparam logic [4:0] FONT_SHORT_LINES = 5'h10;
  localparam logic [7:0] FADE_FULL = 8'hFF;

  // ==========================================================================
  // Timing
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int TRANS_TIME_MS = 500;
  localparam int TRANS_CYCLES_DEF = (CORE_CLK_HZ / 1000) * TRANS_TIME_MS;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARMED,
    MEAS_RUN,
    MEAS_DONE
  } osdfc_meas_t;

endpackage : osdfc_pkg
